// ===== logic/flash_host_pkg.sv
package flash_host_pkg;

  // apb register map of the controller
  localparam logic [7:0] ctrl_off       = 8'h00;
  localparam logic [7:0] addr_off       = 8'h04;
  localparam logic [7:0] wdata_off      = 8'h08;
  localparam logic [7:0] status_off     = 8'h0c;
  localparam logic [7:0] rdata_off      = 8'h10;
  localparam logic [7:0] timing_off     = 8'h14;

  // ctrl fields: go bit and command code
  localparam int         ctrl_go_bit    = 31;
  localparam int         ctrl_cmd_lsb   = 0;
  localparam int         ctrl_cmd_w     = 4;

  // status fields
  localparam int         st_busy_bit    = 0;
  localparam int         st_ready_bit   = 1;
  localparam int         st_done_bit    = 2;

  localparam logic [7:0] timing_rst     = 8'h04;

  // command codes written into ctrl
  typedef enum logic [3:0] {
    op_read         = 4'h0,
    op_reset        = 4'h1,
    op_id_read      = 4'h2,
    op_protect_vfy  = 4'h3,
    op_program      = 4'h4,
    op_chip_erase   = 4'h5,
    op_sector_erase = 4'h6,
    op_suspend      = 4'h7,
    op_resume       = 4'h8,
    op_sector_add   = 4'h9
  } op_t;

  // flash bus constants
  localparam int          addr_w        = 21;
  localparam logic [10:0] unlock_a1     = 11'h555;
  localparam logic [10:0] unlock_a2     = 11'h2aa;
  localparam logic [7:0]  unlock_d1     = 8'haa;
  localparam logic [7:0]  unlock_d2     = 8'h55;
  localparam logic [7:0]  cmd_reset     = 8'hf0;
  localparam logic [7:0]  cmd_id        = 8'h90;
  localparam logic [7:0]  cmd_program   = 8'ha0;
  localparam logic [7:0]  cmd_erase_set = 8'h80;
  localparam logic [7:0]  cmd_chip      = 8'h10;
  localparam logic [7:0]  cmd_sector    = 8'h30;
  localparam logic [7:0]  cmd_suspend   = 8'hb0;
  localparam logic [7:0]  cmd_resume    = 8'h30;
  localparam logic [7:0]  protect_low   = 8'h02;
  localparam int          group_lsb     = 18;
  localparam int          sector_lsb    = 16;

  // flash pin group driven by the controller
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              reset_n;
    logic [addr_w-1:0] address_lines;
    logic [7:0]        data_out;
    logic              data_oe;
  } flash_pins_t;

endpackage

// ===== logic/flash_host.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module flash_host #(
  parameter int setup_cycles = 4
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output flash_host_pkg::flash_pins_t flash_out,
  input  wire logic [7:0]  data_lines_in,
  input  wire logic        ready_busy_out
);

  typedef enum {st_idle, st_setup, st_low, st_high, st_rd_low, st_rd_wait, st_gap} state_t;

  state_t                  state_q, state_d;
  logic [3:0]              cmd_q;
  logic [flash_host_pkg::addr_w-1:0] addr_q;
  logic [7:0]              wdata_q;
  logic [7:0]              rdata_q;
  logic [7:0]              timing_q;
  logic [7:0]              cnt_q;
  logic [2:0]              idx_q;
  logic [2:0]              nwr;
  logic                    is_read;
  logic                    done_q;
  logic [2:0]              rb_sync_q;
  logic                    rb_q;
  logic [10:0]             seq_a;
  logic [7:0]              seq_d;
  logic [flash_host_pkg::addr_w-1:0] cyc_addr;
  flash_host_pkg::flash_pins_t pins_q;

  wire wr_en    = psel && penable && pwrite;
  wire busy     = (state_q != st_idle);
  wire ctrl_hit = wr_en && (paddr == flash_host_pkg::ctrl_off);
  wire go       = ctrl_hit && pwdata[flash_host_pkg::ctrl_go_bit] && !busy;
  wire cnt_end  = (cnt_q == 8'h00);
  wire last_cyc = (idx_q == nwr - 3'd1);

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // number of bus cycles per command
  always_comb begin
    nwr     = 3'd1;
    is_read = 1'b0;
    unique case (flash_host_pkg::op_t'(cmd_q))
      flash_host_pkg::op_read:         is_read = 1'b1;
      flash_host_pkg::op_id_read:      nwr = 3'd4;
      flash_host_pkg::op_protect_vfy:  nwr = 3'd4;
      flash_host_pkg::op_program:      nwr = 3'd4;
      flash_host_pkg::op_chip_erase:   nwr = 3'd6;
      flash_host_pkg::op_sector_erase: nwr = 3'd6;
      default:                         nwr = 3'd1;
    endcase
  end

  // cycle table; id and protect add a read after three writes
  always_comb begin
    seq_a = flash_host_pkg::unlock_a1;
    seq_d = flash_host_pkg::unlock_d1;
    unique case (idx_q)
      3'd1, 3'd4: begin
        seq_a = flash_host_pkg::unlock_a2;
        seq_d = flash_host_pkg::unlock_d2;
      end
      3'd2: begin
        unique case (flash_host_pkg::op_t'(cmd_q))
          flash_host_pkg::op_program: seq_d = flash_host_pkg::cmd_program;
          flash_host_pkg::op_chip_erase,
          flash_host_pkg::op_sector_erase: seq_d = flash_host_pkg::cmd_erase_set;
          default: seq_d = flash_host_pkg::cmd_id;
        endcase
      end
      3'd5: seq_d = (cmd_q == flash_host_pkg::op_chip_erase) ?
                    flash_host_pkg::cmd_chip : flash_host_pkg::cmd_sector;
      default: seq_d = flash_host_pkg::unlock_d1;
    endcase
  end

  // actual address and data per cycle
  always_comb begin
    cyc_addr = {{(flash_host_pkg::addr_w-11){1'b0}}, seq_a};
    unique case (flash_host_pkg::op_t'(cmd_q))
      flash_host_pkg::op_read: cyc_addr = addr_q;
      flash_host_pkg::op_reset, flash_host_pkg::op_suspend,
      flash_host_pkg::op_resume: cyc_addr = addr_q;
      flash_host_pkg::op_sector_add: cyc_addr = addr_q;
      flash_host_pkg::op_program:
        if (idx_q == 3'd3) cyc_addr = addr_q;
      flash_host_pkg::op_sector_erase:
        if (idx_q == 3'd5) cyc_addr = {addr_q[flash_host_pkg::addr_w-1:flash_host_pkg::sector_lsb],
                                       {flash_host_pkg::sector_lsb{1'b0}}};
      flash_host_pkg::op_id_read:
        if (idx_q == 3'd3) cyc_addr = {{(flash_host_pkg::addr_w-2){1'b0}}, addr_q[1:0]};
      flash_host_pkg::op_protect_vfy:
        if (idx_q == 3'd3) cyc_addr = {addr_q[flash_host_pkg::addr_w-1:flash_host_pkg::group_lsb],
          {(flash_host_pkg::group_lsb-8){1'b0}}, flash_host_pkg::protect_low};
      default: cyc_addr = {{(flash_host_pkg::addr_w-11){1'b0}}, seq_a};
    endcase
  end

  wire [7:0] cyc_data =
    (cmd_q == flash_host_pkg::op_reset)      ? flash_host_pkg::cmd_reset :
    (cmd_q == flash_host_pkg::op_suspend)    ? flash_host_pkg::cmd_suspend :
    (cmd_q == flash_host_pkg::op_resume)     ? flash_host_pkg::cmd_resume :
    (cmd_q == flash_host_pkg::op_sector_add) ? flash_host_pkg::cmd_sector :
    (cmd_q == flash_host_pkg::op_program && idx_q == 3'd3) ? wdata_q : seq_d;
  wire cyc_is_read = is_read || (idx_q == 3'd3 &&
    (cmd_q == flash_host_pkg::op_id_read || cmd_q == flash_host_pkg::op_protect_vfy));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // start through one gap cycle so command and index are settled at setup
      st_idle:    if (go) state_d = st_gap;
      st_setup:   if (cnt_end) state_d = cyc_is_read ? st_rd_low : st_low;
      st_low:     if (cnt_end) state_d = st_high;
      st_high:    if (cnt_end) state_d = last_cyc ? st_idle : st_gap;
      st_rd_low:  if (cnt_end) state_d = st_rd_wait;
      st_rd_wait: state_d = st_idle;
      st_gap:     state_d = st_setup;
    endcase
  end

  wire [7:0] cnt_load = (state_d != state_q) ? timing_q : cnt_q - 8'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      cnt_q   <= 8'h00;
      idx_q   <= 3'd0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_end && state_d == state_q ? 8'h00 : cnt_load;
      idx_q   <= go ? 3'd0 : (state_q == st_high && state_d == st_gap) ? idx_q + 3'd1 : idx_q;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q    <= 4'h0;
      addr_q   <= '0;
      wdata_q  <= 8'h00;
      timing_q <= flash_host_pkg::timing_rst;
      done_q   <= 1'b0;
    end else begin
      if (go) cmd_q <= pwdata[flash_host_pkg::ctrl_cmd_lsb +: flash_host_pkg::ctrl_cmd_w];
      if (wr_en && paddr == flash_host_pkg::addr_off && !busy)
        addr_q <= pwdata[flash_host_pkg::addr_w-1:0];
      if (wr_en && paddr == flash_host_pkg::wdata_off && !busy) wdata_q <= pwdata[7:0];
      if (wr_en && paddr == flash_host_pkg::timing_off && pwdata[7:0] != 8'h00)
        timing_q <= pwdata[7:0];
      done_q   <= (busy && state_d == st_idle) ? 1'b1 : (go ? 1'b0 : done_q);
    end
  end

  // read data capture and pin register; data held past we rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
      pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                   address_lines: '0, data_out: 8'h00, data_oe: 1'b0};
    end else begin
      if (state_q == st_rd_wait) rdata_q <= data_lines_in;
      pins_q.reset_n <= 1'b1;
      pins_q.ce_n    <= !(state_d inside {st_setup, st_low, st_high, st_rd_low, st_rd_wait});
      pins_q.we_n    <= !(state_d == st_low);
      pins_q.oe_n    <= !(state_d inside {st_rd_low, st_rd_wait});
      pins_q.data_oe <= (state_d inside {st_setup, st_low, st_high}) && !cyc_is_read;
      if (state_d == st_setup) begin
        pins_q.address_lines <= cyc_addr;
        pins_q.data_out      <= cyc_data;
      end
    end
  end

  assign flash_out = pins_q;

  // ready/busy pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_sync_q <= 3'b111;
      rb_q      <= 1'b1;
    end else begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_out};
      if (rb_sync_q[2] == rb_sync_q[1]) rb_q <= rb_sync_q[2];
    end
  end

  wire [31:0] status_w = {29'h0, done_q, rb_q, busy};

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      flash_host_pkg::ctrl_off:   prdata = {28'h0, cmd_q};
      flash_host_pkg::addr_off:   prdata = {11'h0, addr_q};
      flash_host_pkg::wdata_off:  prdata = {24'h0, wdata_q};
      flash_host_pkg::status_off: prdata = status_w;
      flash_host_pkg::rdata_off:  prdata = {24'h0, rdata_q};
      flash_host_pkg::timing_off: prdata = {24'h0, timing_q};
      default:                    prdata = 32'h0000_0000;
    endcase
  end

endmodule

// ===== tb/flash_host_props.sv
`timescale 1ns/1ps
module flash_host_props #(
  parameter int setup_cycles = 4
) (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // flash side
  input wire flash_host_pkg::flash_pins_t flash_out,
  input wire logic        ready_busy_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire flash_host_pkg::flash_pins_t p = flash_out;
  wire go = psel && penable && pwrite && paddr == flash_host_pkg::ctrl_off && pwdata[31];
  chk_we_frame: assert property (!p.we_n |-> !p.ce_n && p.oe_n && p.data_oe)
    else $error("write strobe outside frame");
  chk_we_width: assert property ($fell(p.we_n) |-> !p.we_n [*5] ##1 p.we_n)
    else $error("write strobe width");
  chk_addr_held: assert property (!p.we_n && $past(!p.we_n) |-> $stable(p.address_lines))
    else $error("address moved in strobe");
  chk_data_hold: assert property ($rose(p.we_n) |-> (p.data_oe && $stable(p.data_out)) [*5])
    else $error("data not held");
  chk_addr_setup: assert property ($fell(p.we_n) |-> $past(!p.ce_n, 4))
    else $error("no setup before strobe");
  chk_read_len: assert property ($fell(p.oe_n) |-> !p.oe_n [*6] ##1 p.oe_n)
    else $error("read strobe width");
  chk_no_fight: assert property (!p.oe_n |-> !p.data_oe && p.we_n)
    else $error("bus contention");
  chk_go_starts: assert property (go |-> ##[1:30] !p.ce_n)
    else $error("command not started");
  chk_pin_quiet: assert property (p.reset_n && !pslverr)
    else $error("reset pin or error");
  cover property ($fell(p.we_n));
  cover property ($fell(p.oe_n));
  cover property ($fell(ready_busy_out));
endmodule
bind flash_host flash_host_props #(.setup_cycles(setup_cycles)) i_flash_host_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .flash_out(flash_out),
  .ready_busy_out(ready_busy_out));

// ===== tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] maker_code = 8'h5a, // arbitrary value
  parameter logic [7:0] part_code  = 8'h6b, // arbitrary value
  parameter logic [7:0] prot_mask  = 8'h08,
  parameter int         prog_ns    = 2000,
  parameter int         erase_ns   = 20000
) (
  // controller pins
  input  wire flash_host_pkg::flash_pins_t pins,
  // device outputs
  output logic [7:0] data_lines,
  output logic       ready_busy_out
);
  logic [7:0]  mem [int];
  logic [20:0] a, ra;
  logic [7:0]  d, pd, rv, last = 8'h00;
  int          s = 0, mode = 0, ret = 0, left = 0;
  logic        tog = 0;
  int          kill [$];
  wire         busy = mode == 2 || mode == 3;
  assign ready_busy_out = !busy;
  // released bus shows the inverse of the last value
  assign data_lines = (!pins.ce_n && !pins.oe_n) ? rv : ~last;
  always #10 if (busy) begin
    left = left - 10;
    if (left <= 0) mode = (mode == 2) ? ret : 0;
  end
  always @(negedge pins.oe_n) begin
    ra = pins.address_lines;
    tog = ~tog;
    if (busy) rv = {mode == 2 ? ~pd[7] : 1'b0, tog, 6'h00};
    else if (mode == 1 && ra[7:0] == 8'h02) rv = {7'h0, prot_mask[ra[20:18]]};
    else if (mode == 1) rv = ra[0] ? part_code : maker_code;
    else rv = mem.exists(ra) ? mem[ra] : 8'hff;
  end
  always @(posedge pins.oe_n) last = rv;
  always @(negedge pins.reset_n) mode = 0;
  always @(negedge pins.we_n) a = pins.address_lines;
  always @(posedge pins.we_n) begin
    d = pins.data_out;
    if (mode == 3 && d == 8'hb0) mode = 4;
    else if (mode == 4 && s == 0 && d == 8'h30) mode = 3;
    else if (!busy) step();
  end
  task automatic go(input int m, input int t);
    ret = mode == 4 ? 4 : 0;
    mode = m;
    left = t;
    s = 0;
  endtask
  task automatic step();
    logic u1, u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2aa;
    if (d == 8'hf0) begin
      s = 0;
      mode = 0;
    end else if ((s == 0 || s == 4) && u1 && d == 8'haa) s = s + 1;
    else if ((s == 1 || s == 5) && u2 && d == 8'h55) s = s + 1;
    else if (s == 2 && u1 && d == 8'h90) go(1, 0);
    else if (s == 2 && u1 && d == 8'ha0) s = 3;
    else if (s == 2 && u1 && d == 8'h80) s = 4;
    else if (s == 3) begin
      mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d;
      pd = d;
      go(2, prog_ns);
    end else if (s == 6 && u1 && d == 8'h10) begin
      mem.delete();
      go(3, erase_ns);
    end else if (s == 6 && d == 8'h30) begin
      kill.delete();
      foreach (mem[k]) if (k[20:16] == a[20:16]) kill.push_back(k);
      foreach (kill[i]) mem.delete(kill[i]);
      go(3, erase_ns);
    end else begin
      s = 0;
      mode = mode == 4 ? 4 : 0;
    end
  endtask
endmodule

// ===== tb/tb_flash_host.sv
`timescale 1ns/1ps
module tb_flash_host;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, rb;
  logic [7:0]  paddr = 8'h00, dl;
  logic [31:0] pwdata = 32'h0, prdata, rv, r1;
  flash_host_pkg::flash_pins_t fo;
  int          n_fail = 0;
  int          cmp_count = 0;
  always #5 pclk = ~pclk;
  flash_host i_flash_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .flash_out(fo), .data_lines_in(dl), .ready_busy_out(rb));
  flash_dev_model i_flash_dev_model (.pins(fo), .data_lines(dl), .ready_busy_out(rb));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (k >= 50) chk("pready", 0, 1);
    if (k >= 50) conclude();
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(0, flash_host_pkg::status_off, 32'h0);
      k++;
    end while (rv[b] !== v && k < 3000);
    if (k >= 3000) chk("wait", 0, 1);
    if (k >= 3000) conclude();
  endtask
  task automatic run(input flash_host_pkg::op_t c, input logic [20:0] a, input logic [7:0] d);
    apb(1, flash_host_pkg::addr_off, {11'h0, a});
    apb(1, flash_host_pkg::wdata_off, {24'h0, d});
    apb(1, flash_host_pkg::ctrl_off, {1'b1, 27'h0, c});
    poll(flash_host_pkg::st_busy_bit, 0);
    apb(0, flash_host_pkg::rdata_off, 32'h0);
  endtask
  task automatic rdf(input flash_host_pkg::op_t c, input logic [20:0] a, input logic [7:0] e);
    run(c, a, 8'h00);
    chk("read data", rv, {24'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(1, flash_host_pkg::timing_off, 32'h0);
    apb(0, flash_host_pkg::timing_off, 32'h0);
    chk("timing", rv, {24'h0, flash_host_pkg::timing_rst});
    apb(0, 8'h1c, 32'h0);
    chk("unmapped", rv, 32'h0);
    apb(0, flash_host_pkg::status_off, 32'h0);
    chk("status", rv & 32'h7, 32'h2);
    $display("test registers done");
    run(flash_host_pkg::op_program, 21'h012345, 8'h3c);
    run(flash_host_pkg::op_read, 21'h012345, 8'h00);
    r1 = rv;
    run(flash_host_pkg::op_read, 21'h012345, 8'h00);
    chk("poll bit", rv & 32'h80, 32'h80);
    chk("toggle bit", (rv ^ r1) & 32'h40, 32'h40);
    run(flash_host_pkg::op_program, 21'h000010, 8'h00);
    poll(flash_host_pkg::st_ready_bit, 1);
    rdf(flash_host_pkg::op_read, 21'h012345, 8'h3c);
    rdf(flash_host_pkg::op_read, 21'h000010, 8'hff);
    apb(0, flash_host_pkg::status_off, 32'h0);
    chk("status done", rv & 32'h7, 32'h6);
    $display("test program done");
    rdf(flash_host_pkg::op_id_read, 21'h000000, 8'h5a);
    rdf(flash_host_pkg::op_id_read, 21'h000001, 8'h6b);
    rdf(flash_host_pkg::op_protect_vfy, 21'h0c0000, 8'h01);
    rdf(flash_host_pkg::op_protect_vfy, 21'h080000, 8'h00);
    run(flash_host_pkg::op_reset, 21'h000000, 8'h00);
    rdf(flash_host_pkg::op_read, 21'h012345, 8'h3c);
    $display("test identify done");
    run(flash_host_pkg::op_program, 21'h000020, 8'h5a);
    poll(flash_host_pkg::st_ready_bit, 1);
    run(flash_host_pkg::op_sector_erase, 21'h010000, 8'h00);
    run(flash_host_pkg::op_sector_add, 21'h1f0000, 8'h00);
    run(flash_host_pkg::op_program, 21'h000030, 8'h00);
    run(flash_host_pkg::op_suspend, 21'h000000, 8'h00);
    rdf(flash_host_pkg::op_read, 21'h000020, 8'h5a);
    run(flash_host_pkg::op_resume, 21'h000000, 8'h00);
    poll(flash_host_pkg::st_ready_bit, 1);
    rdf(flash_host_pkg::op_read, 21'h012345, 8'hff);
    rdf(flash_host_pkg::op_read, 21'h000030, 8'hff);
    rdf(flash_host_pkg::op_read, 21'h000020, 8'h5a);
    run(flash_host_pkg::op_chip_erase, 21'h000000, 8'h00);
    poll(flash_host_pkg::st_ready_bit, 1);
    rdf(flash_host_pkg::op_read, 21'h000020, 8'hff);
    $display("test erase done");
    conclude();
  end
endmodule
